// ---- board_model.sv ----
// Board side of the shared pins
// Assumes ext_level is what the board puts on released pads
`timescale 1ns/1ns
`default_nettype none
module board_model
(
    input  wire logic [14:0] pin_out,
    input  wire logic [14:0] pin_oe,
    input  wire logic [14:0] ext_level,
    output wire logic [14:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ---- pin_share_cell.v ----
// One shared pin: peripheral output beats port output
// Assumes synchronous pin inputs and one clock mclk
`timescale 1ns/1ns
`default_nettype none

`include "pin_share_map.vh"

module pin_share_cell
(
    input  wire mclk,
    input  wire sys_rst,
    input  wire periph_out_en,
    input  wire periph_out,
    input  wire periph_oe,
    input  wire port_dir,
    input  wire port_out,
    input  wire pin_in,
    output reg  pin_out_ff,
    output reg  pin_oe_ff,
    output reg  port_in_ff
);

    reg nxt_pin_out;
    reg nxt_pin_oe;

    always @*
    begin
        if (periph_out_en)
        begin
            nxt_pin_out = periph_out;
            nxt_pin_oe  = periph_oe;
        end
        else
        begin
            nxt_pin_out = port_out;
            nxt_pin_oe  = port_dir;
        end
    end

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out_ff <= `PIN_RST_LEVEL;
            pin_oe_ff  <= `PIN_RST_OE;
            port_in_ff <= `PIN_RST_LEVEL;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
            port_in_ff <= pin_in;
        end
    end

endmodule

`default_nettype wire

// ---- pin_share_map.vh ----
// Constants for the shared pin function select block
// Assumes inclusion by pin_share_top.v and pin_share_cell.v
`ifndef PIN_SHARE_MAP_VH
`define PIN_SHARE_MAP_VH

// Reset value of every registered pin output
`define PIN_RST_LEVEL     1'h0
// Reset value of registered output enables: all released
`define PIN_RST_OE        1'h0
// Reset value of routed peripheral inputs: idle high
`define PIN_RST_IN_IDLE   1'h1
// Reset value of the analog route select
`define PIN_RST_ANALOG    1'h0
// Bit position of analog channel ten in analog_input_select_two
`define ANALOG_TEN_BIT    2
// Width of analog_input_select_two
`define ANALOG_SEL2_W     7
// Reset value of the three routed trigger inputs: idle high
`define PIN_RST_TRIG      3'h7
// Reset value of the two-channel routed serial inputs: idle high
`define PIN_RST_SER       2'h3

`endif

// ---- pin_share_top.v ----
// Pin-sharing select for analog, interrupt, pulse, timer and serial pins
// Assumes peripheral enables come from software registers elsewhere
`timescale 1ns/1ns
`default_nettype none

`include "pin_share_map.vh"

module pin_share_top
(
    input  wire                      mclk,
    input  wire                      sys_rst,
    // Software enables
    input  wire [`ANALOG_SEL2_W-1:0] analog_input_select_two,
    input  wire                      ext_irq_four_en,
    input  wire                      ext_irq_five_en,
    input  wire [2:0]                pulse_out_en,
    input  wire [2:0]                reload_trig_en,
    input  wire [1:0]                reload_out_en,
    input  wire [1:0]                serial_tx_en,
    input  wire [1:0]                serial_rx_en,
    input  wire [1:0]                serial_clk_out_en,
    // Peripheral signals
    input  wire [2:0]                pulse_wave,
    input  wire [1:0]                reload_wave,
    input  wire [1:0]                serial_tx_data,
    input  wire [1:0]                serial_clk_drive,
    // Port registers: pins 0..7 of port0, then port1 bits 0..5, port4_bit6
    input  wire [14:0]               port_dir,
    input  wire [14:0]               port_out,
    // Pads
    input  wire [14:0]               pin_in,
    input  wire                      nmi_pin_n,
    output wire [14:0]               pin_out,
    output wire [14:0]               pin_oe,
    output wire [14:0]               port_in,
    // Routed peripheral inputs
    output reg                       analog_ten_sel_ff,
    output reg                       nmi_req_n_ff,
    output reg                       ext_irq_four_ff,
    output reg                       ext_irq_five_ff,
    output reg  [2:0]                reload_trig_ff,
    output reg  [1:0]                serial_rx_ff,
    output reg  [1:0]                serial_clk_in_ff
);

    // Pin indices inside the pin vectors
    localparam PORT0_BIT0 = 0;
    localparam PORT0_BIT2 = 2;
    localparam PORT0_BIT3 = 3;
    localparam PORT0_BIT4 = 4;
    localparam PORT0_BIT5 = 5;
    localparam PORT0_BIT6 = 6;
    localparam PORT0_BIT7 = 7;
    localparam PORT1_BIT0 = 8;
    localparam PORT1_BIT1 = 9;
    localparam PORT1_BIT2 = 10;
    localparam PORT1_BIT3 = 11;
    localparam PORT1_BIT4 = 12;
    localparam PORT1_BIT5 = 13;
    localparam PORT4_BIT6 = 14;

    reg [14:0] sel_en;
    reg [14:0] sel_out;
    reg [14:0] sel_oe;
    reg [14:0] port_oe_mask;
    reg [14:0] eff_dir;

    // Input gate: pin level when function enabled, else idle high
    function gate_in;
        input en;
        input lvl;
        begin
            gate_in = en ? lvl : `PIN_RST_IN_IDLE;
        end
    endfunction

    always @*
    begin
        sel_en  = 15'h0000;
        sel_out = 15'h0000;
        sel_oe  = 15'h0000;
        port_oe_mask = 15'h7fff;
        sel_en[PORT0_BIT2:PORT0_BIT0]  = pulse_out_en;
        sel_out[PORT0_BIT2:PORT0_BIT0] = pulse_wave;
        sel_oe[PORT0_BIT2:PORT0_BIT0]  = pulse_out_en;
        // Reload output pins, none for timer zero
        sel_en[PORT0_BIT7:PORT0_BIT6]  = reload_out_en;
        sel_out[PORT0_BIT7:PORT0_BIT6] = reload_wave;
        sel_oe[PORT0_BIT7:PORT0_BIT6]  = reload_out_en;
        // Serial transmit pins, channel one alike
        sel_en[PORT1_BIT0]  = serial_tx_en[0];
        sel_out[PORT1_BIT0] = serial_tx_data[0];
        sel_oe[PORT1_BIT0]  = serial_tx_en[0];
        sel_en[PORT1_BIT3]  = serial_tx_en[1];
        sel_out[PORT1_BIT3] = serial_tx_data[1];
        sel_oe[PORT1_BIT3]  = serial_tx_en[1];
        // Two-way serial clock pins, channel one alike
        sel_en[PORT1_BIT2]  = serial_clk_out_en[0];
        sel_out[PORT1_BIT2] = serial_clk_drive[0];
        sel_oe[PORT1_BIT2]  = serial_clk_out_en[0];
        sel_en[PORT1_BIT5]  = serial_clk_out_en[1];
        sel_out[PORT1_BIT5] = serial_clk_drive[1];
        sel_oe[PORT1_BIT5]  = serial_clk_out_en[1];
        sel_en[PORT4_BIT6]  = analog_input_select_two[`ANALOG_TEN_BIT];
        // Interrupt inputs share pulse zero and two pins
        if (!pulse_out_en[0] && ext_irq_four_en)
            sel_en[PORT0_BIT0] = 1'b1;
        if (!pulse_out_en[2] && ext_irq_five_en)
            sel_en[PORT0_BIT2] = 1'b1;
        // Trigger pins: port driver held off while trigger on
        if (reload_trig_en[0])
            port_oe_mask[PORT0_BIT3] = 1'b0;
        if (reload_trig_en[1])
            port_oe_mask[PORT0_BIT4] = 1'b0;
        if (reload_trig_en[2])
            port_oe_mask[PORT0_BIT5] = 1'b0;
        // Receive pins: port output held off, channel one alike
        if (serial_rx_en[0])
            port_oe_mask[PORT1_BIT1] = 1'b0;
        if (serial_rx_en[1])
            port_oe_mask[PORT1_BIT4] = 1'b0;
        // Disabled functions leave plain port direction
        eff_dir = port_dir & port_oe_mask;
    end

    genvar g;
    generate
        for (g = 0; g < 15; g = g + 1)
        begin : pin_gen
            pin_share_cell u_cell
            (
                .mclk          (mclk),
                .sys_rst       (sys_rst),
                .periph_out_en (sel_en[g]),
                .periph_out    (sel_out[g]),
                .periph_oe     (sel_oe[g]),
                .port_dir      (eff_dir[g]),
                .port_out      (port_out[g]),
                .pin_in        (pin_in[g]),
                .pin_out_ff    (pin_out[g]),
                .pin_oe_ff     (pin_oe[g]),
                .port_in_ff    (port_in[g])
            );
        end
    endgenerate

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            analog_ten_sel_ff <= `PIN_RST_ANALOG;
            nmi_req_n_ff      <= `PIN_RST_IN_IDLE;
            ext_irq_four_ff   <= `PIN_RST_IN_IDLE;
            ext_irq_five_ff   <= `PIN_RST_IN_IDLE;
            reload_trig_ff    <= `PIN_RST_TRIG;
            serial_rx_ff      <= `PIN_RST_SER;
            serial_clk_in_ff  <= `PIN_RST_SER;
        end
        else
        begin
            analog_ten_sel_ff <= analog_input_select_two[`ANALOG_TEN_BIT];
            nmi_req_n_ff      <= nmi_pin_n;
            ext_irq_four_ff   <= gate_in(ext_irq_four_en,
                                         pin_in[PORT0_BIT0]);
            ext_irq_five_ff   <= gate_in(ext_irq_five_en,
                                         pin_in[PORT0_BIT2]);
            reload_trig_ff[0] <= gate_in(reload_trig_en[0],
                                         pin_in[PORT0_BIT3]);
            reload_trig_ff[1] <= gate_in(reload_trig_en[1],
                                         pin_in[PORT0_BIT4]);
            reload_trig_ff[2] <= gate_in(reload_trig_en[2],
                                         pin_in[PORT0_BIT5]);
            serial_rx_ff[0]   <= gate_in(serial_rx_en[0],
                                         pin_in[PORT1_BIT1]);
            serial_rx_ff[1]   <= gate_in(serial_rx_en[1],
                                         pin_in[PORT1_BIT4]);
            // Clock pins always readable for external clock
            serial_clk_in_ff[0] <= pin_in[PORT1_BIT2];
            serial_clk_in_ff[1] <= pin_in[PORT1_BIT5];
        end
    end

endmodule

`default_nettype wire

// ---- pin_share_top_properties.sv ----
// Timing properties of pin_share_top
// Assumes binding to pin_share_top, one clock mclk
`timescale 1ns/1ns
`default_nettype none
module pin_share_props
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [6:0]  analog_input_select_two,
    input wire logic        ext_irq_four_en,
    input wire logic [2:0]  pulse_out_en,
    input wire logic [2:0]  reload_trig_en,
    input wire logic [1:0]  reload_out_en,
    input wire logic [1:0]  serial_tx_en,
    input wire logic [1:0]  serial_rx_en,
    input wire logic [1:0]  serial_clk_out_en,
    input wire logic [2:0]  pulse_wave,
    input wire logic [1:0]  reload_wave,
    input wire logic [1:0]  serial_tx_data,
    input wire logic [1:0]  serial_clk_drive,
    input wire logic [14:0] port_dir,
    input wire logic [14:0] pin_in,
    input wire logic        nmi_pin_n,
    input wire logic [14:0] pin_out,
    input wire logic [14:0] pin_oe,
    input wire logic [14:0] port_in,
    input wire logic        analog_ten_sel_ff,
    input wire logic        nmi_req_n_ff,
    input wire logic [2:0]  reload_trig_ff,
    input wire logic [1:0]  serial_rx_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_rx_on;
        serial_rx_en[0] ##1 !pin_oe[9];
    endsequence
    property p_pulse;
        pulse_out_en[0] |=> pin_oe[0] && pin_out[0] == $past(pulse_wave[0]);
    endproperty
    property p_port01;
        !pulse_out_en[1] |=> pin_oe[1] == $past(port_dir[1]);
    endproperty
    property p_irq_off;
        !pulse_out_en[0] && ext_irq_four_en |=> !pin_oe[0];
    endproperty
    property p_trig;
        reload_trig_en[0] |=> !pin_oe[3] &&
            reload_trig_ff[0] == $past(pin_in[3]);
    endproperty
    property p_trig_port;
        !reload_trig_en[1] |=> pin_oe[4] == $past(port_dir[4]);
    endproperty
    property p_tmr_out;
        reload_out_en[1] |=> pin_oe[7] &&
            pin_out[7] == $past(reload_wave[1]);
    endproperty
    property p_tx;
        serial_tx_en[1] |=> pin_oe[11] &&
            pin_out[11] == $past(serial_tx_data[1]);
    endproperty
    property p_rx;
        s_rx_on |-> serial_rx_ff[0] == $past(pin_in[9]);
    endproperty
    property p_clk;
        serial_clk_out_en[0] |=> pin_oe[10] &&
            pin_out[10] == $past(serial_clk_drive[0]);
    endproperty
    property p_analog;
        analog_input_select_two[2] |=> analog_ten_sel_ff && !pin_oe[14];
    endproperty
    property p_nmi;
        !nmi_pin_n |=> !nmi_req_n_ff;
    endproperty
    property p_sample;
        1'b1 |=> port_in == $past(pin_in);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse pin");
    a_port01: assert property (p_port01) else $error("port0 bit1");
    a_irq_off: assert property (p_irq_off) else $error("irq pin");
    a_trig: assert property (p_trig) else $error("trigger");
    a_trig_port: assert property (p_trig_port) else $error("trig port");
    a_tmr_out: assert property (p_tmr_out) else $error("timer out");
    a_tx: assert property (p_tx) else $error("serial tx");
    a_rx: assert property (p_rx) else $error("serial rx");
    a_clk: assert property (p_clk) else $error("serial clk");
    a_analog: assert property (p_analog) else $error("analog");
    a_nmi: assert property (p_nmi) else $error("nmi");
    a_sample: assert property (p_sample) else $error("port in");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for pin_share_top
// Assumes board_model on the pads and the bound checker
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        mclk, sys_rst, ext_irq_four_en, ext_irq_five_en, nmi_pin_n;
    logic [6:0]  analog_input_select_two;
    logic [2:0]  pulse_out_en, reload_trig_en, pulse_wave;
    logic [1:0]  reload_out_en, serial_tx_en, serial_rx_en, serial_clk_out_en;
    logic [1:0]  reload_wave, serial_tx_data, serial_clk_drive;
    logic [14:0] port_dir, port_out, ext_level;
    wire  [14:0] pin_in, pin_out, pin_oe, port_in;
    wire         analog_ten_sel_ff, nmi_req_n_ff;
    wire         ext_irq_four_ff, ext_irq_five_ff;
    wire  [2:0]  reload_trig_ff;
    wire  [1:0]  serial_rx_ff, serial_clk_in_ff;
    int          err_count, samples_checked;
    pin_share_top u_pin_share_top (.mclk, .sys_rst, .analog_input_select_two,
        .ext_irq_four_en, .ext_irq_five_en, .pulse_out_en, .reload_trig_en,
        .reload_out_en, .serial_tx_en, .serial_rx_en, .serial_clk_out_en,
        .pulse_wave, .reload_wave, .serial_tx_data, .serial_clk_drive,
        .port_dir, .port_out, .pin_in, .nmi_pin_n, .pin_out, .pin_oe, .port_in,
        .analog_ten_sel_ff, .nmi_req_n_ff, .ext_irq_four_ff, .ext_irq_five_ff,
        .reload_trig_ff, .serial_rx_ff, .serial_clk_in_ff);
    board_model u_board_model (.pin_out, .pin_oe, .ext_level, .pin_in);
    task automatic chk(input string nm, input logic [14:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic summarize;
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_pulse;
        pulse_out_en = 3'h7; pulse_wave = 3'h5; settle;
        chk("pls_oe", 15'h0007, pin_oe[2:0]);
        chk("pls_out", 15'h0005, pin_out[2:0]);
        pulse_out_en = 3'h0; ext_irq_four_en = 1'h1; port_out = 15'h0002; settle;
        chk("p0_oe", 15'h0006, pin_oe[2:0]);
        chk("p0_out", 15'h0002, pin_out[2:0] & 3'h6);
        chk("irq4", 15'h0000, ext_irq_four_ff);
        ext_irq_four_en = 1'h0; ext_irq_five_en = 1'h1; settle;
        chk("p0_oe2", 15'h0003, pin_oe[2:0]);
        chk("irq5", 15'h0000, ext_irq_five_ff);
        ext_irq_five_en = 1'h0;
    endtask
    task automatic t_timer;
        ext_level = 15'h0028; reload_trig_en = 3'h7; port_out = 15'h0000; settle;
        chk("trg_oe", 15'h0000, pin_oe[5:3]);
        chk("trg_in", 15'h0005, reload_trig_ff);
        reload_trig_en = 3'h0; reload_out_en = 2'h3; reload_wave = 2'h2; settle;
        chk("tmr_oe", 15'h001f, pin_oe[7:3]);
        chk("tmr_out", 15'h0002, pin_out[7:6]);
        chk("trg_idle", 15'h0007, reload_trig_ff);
    endtask
    task automatic t_serial;
        serial_tx_en = 2'h3; serial_tx_data = 2'h1; serial_rx_en = 2'h3;
        serial_clk_out_en = 2'h1; serial_clk_drive = 2'h3; ext_level = 15'h3200;
        settle;
        chk("ser_oe", 15'h002d, pin_oe[13:8]);
        chk("ser_out", 15'h0005, pin_out[13:8] & pin_oe[13:8]);
        chk("ser_rx", 15'h0003, serial_rx_ff);
        chk("ser_clk", 15'h0001, serial_clk_in_ff);
        serial_tx_en = 2'h0; serial_rx_en = 2'h0; serial_clk_out_en = 2'h0;
        port_out = 15'h3f00; settle;
        chk("ser_port", 15'h003f, pin_oe[13:8] & pin_out[13:8]);
    endtask
    task automatic t_analog;
        analog_input_select_two = 7'h04; settle;
        chk("an_sel", 15'h0001, analog_ten_sel_ff);
        chk("an_oe", 15'h0000, pin_oe[14]);
        analog_input_select_two = 7'h7b; nmi_pin_n = 1'h0; settle;
        chk("an_port", 15'h0002, {pin_oe[14], analog_ten_sel_ff});
        chk("nmi", 15'h0000, nmi_req_n_ff);
    endtask
    initial
    begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #20000;
        err_count++;
        summarize();
    end
    initial
    begin
        {sys_rst, nmi_pin_n} = 2'h3;
        {ext_irq_four_en, ext_irq_five_en, analog_input_select_two} = 9'h000;
        {pulse_out_en, reload_trig_en, pulse_wave} = 9'h000;
        {reload_out_en, serial_tx_en, serial_rx_en, serial_clk_out_en} = 8'h00;
        {reload_wave, serial_tx_data, serial_clk_drive} = 6'h00;
        port_dir = 15'h7fff; port_out = 15'h0000; ext_level = 15'h0000;
        repeat (2) @(negedge mclk);
        chk("rst_oe", 15'h0000, pin_oe);
        sys_rst = 1'h0; settle;
        t_pulse(); t_timer(); t_serial(); t_analog();
        summarize();
    end
endmodule
bind pin_share_top pin_share_props u_pin_share_props (.mclk, .sys_rst,
    .analog_input_select_two, .ext_irq_four_en, .pulse_out_en, .reload_trig_en,
    .reload_out_en, .serial_tx_en, .serial_rx_en, .serial_clk_out_en,
    .pulse_wave, .reload_wave, .serial_tx_data, .serial_clk_drive, .port_dir,
    .pin_in, .nmi_pin_n, .pin_out, .pin_oe, .port_in, .analog_ten_sel_ff,
    .nmi_req_n_ff, .reload_trig_ff, .serial_rx_ff);
`default_nettype wire
